// ### rtl/emr_device.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module emr_device (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   emr_link_if.dev LINK,
   input wire logic [7:0] CDR_LOCKED,
   input wire logic [7:0] HOPEN_RAW [8],
   input wire logic [7:0] VOPEN_RAW [8],
   input wire logic [15:0] HIT_COUNT,
   output logic [5:0] MAP_PHASE,
   output logic [5:0] MAP_VOLT,
   output logic [1:0] VRANGE_SEL [8],
   output logic [7:0] MON_ACTIVE
);
   logic [7:0] ch_sel_q;
   logic [7:0] page_q;
   logic [7:0] lock_q [8];
   logic [7:0] scale_q [8];
   logic [7:0] range_q [8];
   logic [7:0] ctrl_q [8];
   logic [7:0] hopen_q [8];
   logic [7:0] vopen_q [8];
   logic [12:0] word_cnt_q;
   logic [11:0] pos_q;
   logic lo_pending_q;
   logic [7:0] lo_byte_q;
   logic [7:0] rdata_q;
   logic [7:0] lock_s1_q, lock_s2_q;
   logic [2:0] ch_idx;
   logic one_ch;
   logic ch_access;
   logic [15:0] cur_word;
   always_comb begin
      ch_idx = 3'h0;
      for (int i = 0; i < emr_pkg::NUM_CH; i++) begin
         if (ch_sel_q[i]) begin
            ch_idx = 3'(i);
         end
      end
   end
   assign one_ch = (ch_sel_q != 8'h00) && ((ch_sel_q & (ch_sel_q - 8'h01)) == 8'h00);
   assign ch_access = page_q[emr_pkg::BIT_PAGE];
   // Junk words carry zero; matrix data comes from the hit counter
   assign cur_word = (word_cnt_q < 13'(emr_pkg::JUNK_WORDS)) ? 16'h0000 : HIT_COUNT;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         lock_s1_q <= 8'h00;
         lock_s2_q <= 8'h00;
      end else if (CLK_EN) begin
         lock_s1_q <= CDR_LOCKED;
         lock_s2_q <= lock_s1_q;
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         ch_sel_q <= emr_pkg::RST_CH_SEL;
         page_q <= emr_pkg::RST_PAGE;
      end else if (CLK_EN && LINK.wr) begin
         if (LINK.addr == emr_pkg::OFF_CH_SEL) begin
            ch_sel_q <= LINK.wdata;
         end
         if (LINK.addr == emr_pkg::OFF_PAGE) begin
            page_q <= LINK.wdata;
         end
      end
   end
   genvar g;
   generate
      for (g = 0; g < emr_pkg::NUM_CH; g++) begin : g_ch
         logic wsel;
         assign wsel = CLK_EN && LINK.wr && ch_access && ch_sel_q[g];
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               lock_q[g] <= emr_pkg::RST_LOCK_MON;
               scale_q[g] <= emr_pkg::RST_SCALE;
               range_q[g] <= emr_pkg::RST_RANGE;
               ctrl_q[g] <= emr_pkg::RST_CTRL;
            end else begin
               if (wsel && LINK.addr == emr_pkg::OFF_LOCK_MON) begin
                  lock_q[g] <= LINK.wdata;
               end
               if (wsel && LINK.addr == emr_pkg::OFF_SCALE) begin
                  scale_q[g] <= LINK.wdata;
               end
               if (wsel && LINK.addr == emr_pkg::OFF_RANGE) begin
                  range_q[g] <= LINK.wdata;
               end
               if (wsel && LINK.addr == emr_pkg::OFF_CTRL) begin
                  ctrl_q[g] <= LINK.wdata;
               end else if (CLK_EN && ctrl_q[g][emr_pkg::BIT_START]) begin
                  ctrl_q[g][emr_pkg::BIT_START] <= 1'b0;
               end
            end
         end
         // Openings refresh only while locked, so the last valid value holds
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               hopen_q[g] <= 8'h00;
               vopen_q[g] <= 8'h00;
            end else if (CLK_EN && lock_s2_q[g]) begin
               hopen_q[g] <= HOPEN_RAW[g];
               vopen_q[g] <= VOPEN_RAW[g];
            end
         end
         always_ff @(posedge CORE_CLK) begin
            if (!RST_N) begin
               VRANGE_SEL[g] <= emr_pkg::AUTO_RANGE;
               MON_ACTIVE[g] <= 1'b0;
            end else if (CLK_EN) begin
               // Auto range when scaling bit set; horizontal scale is never host-owned
               VRANGE_SEL[g] <= scale_q[g][emr_pkg::BIT_SCALE] ? emr_pkg::AUTO_RANGE
                                                                : range_q[g][7:6];
               MON_ACTIVE[g] <= !range_q[g][emr_pkg::BIT_PWRDN] && ctrl_q[g][emr_pkg::BIT_FAST];
            end
         end
      end
   endgenerate
   logic start_wr;
   logic map_rd;
   logic hi_rd;
   logic lo_rd;
   assign start_wr = LINK.wr && ch_access && ch_sel_q[ch_idx] && LINK.addr == emr_pkg::OFF_CTRL
                     && LINK.wdata[emr_pkg::BIT_START];
   assign hi_rd = LINK.rd && ch_access && one_ch && LINK.addr == emr_pkg::OFF_MAP_HI;
   assign lo_rd = LINK.rd && ch_access && one_ch && LINK.addr == emr_pkg::OFF_MAP_LO;
   // A word completes on the lower byte, or on the second byte of a burst
   assign map_rd = lo_rd || (hi_rd && LINK.burst && lo_pending_q);
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         word_cnt_q <= 13'h0000;
         pos_q <= 12'h000;
         lo_pending_q <= 1'b0;
         lo_byte_q <= 8'h00;
      end else if (CLK_EN) begin
         if (start_wr) begin
            word_cnt_q <= 13'h0000;
            pos_q <= 12'h000;
            lo_pending_q <= 1'b0;
         end else if (map_rd) begin
            lo_pending_q <= 1'b0;
            if (word_cnt_q < emr_pkg::WORD_CNT_TOTAL) begin
               word_cnt_q <= word_cnt_q + 13'h0001;
               if (word_cnt_q >= 13'(emr_pkg::JUNK_WORDS)) begin
                  pos_q <= pos_q + 12'h001; // Low bits volt, high bits phase
               end
            end
         end else if (hi_rd) begin
            lo_pending_q <= 1'b1;
            lo_byte_q <= cur_word[7:0];
         end
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         MAP_PHASE <= 6'h00;
         MAP_VOLT <= 6'h00;
      end else if (CLK_EN) begin
         MAP_PHASE <= pos_q[11:6];
         MAP_VOLT <= pos_q[5:0];
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         rdata_q <= 8'h00;
      end else if (CLK_EN && LINK.rd) begin
         if (LINK.addr == emr_pkg::OFF_CH_SEL) begin
            rdata_q <= ch_sel_q;
         end else if (LINK.addr == emr_pkg::OFF_PAGE) begin
            rdata_q <= page_q;
         end else if (!ch_access || !one_ch) begin
            rdata_q <= 8'h00;
         end else begin
            unique case (LINK.addr)
               emr_pkg::OFF_LOCK_MON: rdata_q <= lock_q[ch_idx];
               emr_pkg::OFF_SCALE: rdata_q <= scale_q[ch_idx];
               emr_pkg::OFF_RANGE: rdata_q <= range_q[ch_idx];
               emr_pkg::OFF_CTRL: rdata_q <= ctrl_q[ch_idx];
               emr_pkg::OFF_MAP_HI: rdata_q <= (LINK.burst && lo_pending_q) ? lo_byte_q
                                                                          : cur_word[15:8];
               emr_pkg::OFF_MAP_LO: rdata_q <= cur_word[7:0];
               emr_pkg::OFF_HOPEN: rdata_q <= hopen_q[ch_idx];
               emr_pkg::OFF_VOPEN: rdata_q <= vopen_q[ch_idx];
               default: rdata_q <= 8'h00;
            endcase
         end
      end
   end
   assign LINK.rdata = rdata_q;
endmodule

// ### rtl/emr_pkg.sv
package emr_pkg;
   localparam int NUM_CH = 8;
   localparam int DIM = 64;
   localparam int JUNK_WORDS = 4;
   localparam int MAP_WORDS = DIM * DIM;
   localparam logic [7:0] OFF_LOCK_MON = 8'h67;
   localparam logic [7:0] OFF_SCALE = 8'h2C;
   localparam logic [7:0] OFF_RANGE = 8'h11;
   localparam logic [7:0] OFF_CTRL = 8'h24;
   localparam logic [7:0] OFF_MAP_HI = 8'h25;
   localparam logic [7:0] OFF_MAP_LO = 8'h26;
   localparam logic [7:0] OFF_HOPEN = 8'h27;
   localparam logic [7:0] OFF_VOPEN = 8'h28;
   localparam logic [7:0] OFF_CH_SEL = 8'hFC;
   localparam logic [7:0] OFF_PAGE = 8'hFF;
   localparam int BIT_LOCK_MON = 5;
   localparam int BIT_SCALE = 6;
   localparam int BIT_PWRDN = 5;
   localparam int BIT_FAST = 7;
   localparam int BIT_AUX = 1;
   localparam int BIT_START = 0;
   localparam int BIT_PAGE = 0;
   localparam logic [7:0] RST_LOCK_MON = 8'h20;
   localparam logic [7:0] RST_SCALE = 8'h40;
   localparam logic [7:0] RST_RANGE = 8'h20;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_CH_SEL = 8'h00;
   localparam logic [7:0] RST_PAGE = 8'h00;
   localparam logic [1:0] AUTO_RANGE = 2'h3;
   localparam logic [12:0] WORD_CNT_TOTAL = 13'h1004;
endpackage

// ### rtl/emr_link_if.sv
`timescale 1ns/1ps
interface emr_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic burst;
   logic [7:0] rdata;
   modport dev (input addr, input wdata, input wr, input rd, input burst, output rdata);
   modport host (output addr, output wdata, output wr, output rd, output burst, input rdata);
endinterface

// ### rtl/emr_host.sv
`timescale 1ns/1ps
module emr_host (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic CLK_EN,
   emr_link_if.host LINK,
   input wire logic START,
   input wire logic [2:0] CHANNEL,
   input wire logic [1:0] RANGE,
   output logic WORD_VALID,
   output logic [15:0] WORD_DATA,
   output logic BUSY,
   output logic DONE
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_SEL = 4'h1, S_PAGE = 4'h2, S_LOCK = 4'h3, S_SCALE = 4'h4,
      S_RANGE = 4'h5, S_FAST = 4'h6, S_START = 4'h7, S_RDHI = 4'h8, S_RDLO = 4'h9,
      S_WAIT = 4'hA, S_RLOCK = 4'hB, S_RSCALE = 4'hC, S_RRANGE = 4'hD, S_RCTRL = 4'hE
   } emr_hst_e;
   emr_hst_e st_q;
   logic [12:0] cnt_q;
   logic [7:0] hi_q;
   logic [7:0] addr_q, wdata_q;
   logic wr_q, rd_q, got_lo_q;
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         st_q <= S_IDLE;
         cnt_q <= 13'h0000;
         hi_q <= 8'h00;
         addr_q <= 8'h00;
         wdata_q <= 8'h00;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         got_lo_q <= 1'b0;
         WORD_VALID <= 1'b0;
         WORD_DATA <= 16'h0000;
         BUSY <= 1'b0;
         DONE <= 1'b0;
      end else if (CLK_EN) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         WORD_VALID <= 1'b0;
         DONE <= 1'b0;
         got_lo_q <= 1'b0;
         unique case (st_q)
            S_IDLE: if (START) begin
               BUSY <= 1'b1;
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_CH_SEL;
               wdata_q <= 8'h01 << CHANNEL;
               st_q <= S_SEL;
            end
            S_SEL: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_PAGE;
               wdata_q <= 8'h01;
               st_q <= S_PAGE;
            end
            S_PAGE: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_LOCK_MON;
               wdata_q <= 8'h00;
               st_q <= S_LOCK;
            end
            S_LOCK: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_SCALE;
               wdata_q <= 8'h00;
               st_q <= S_SCALE;
            end
            S_SCALE: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_RANGE;
               wdata_q <= {RANGE, 6'h00}; // Range set and power-down cleared together
               st_q <= S_RANGE;
            end
            S_RANGE: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_CTRL;
               wdata_q <= 8'h80;
               st_q <= S_FAST;
            end
            S_FAST: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_CTRL;
               wdata_q <= 8'h81;
               cnt_q <= 13'h0000;
               st_q <= S_START;
            end
            S_START, S_WAIT: begin
               rd_q <= 1'b1;
               addr_q <= emr_pkg::OFF_MAP_HI;
               st_q <= S_RDHI;
            end
            S_RDHI: begin
               rd_q <= 1'b1;
               addr_q <= emr_pkg::OFF_MAP_LO; // Fresh single-byte access
               st_q <= S_RDLO;
            end
            S_RDLO: begin
               hi_q <= LINK.rdata;
               got_lo_q <= 1'b1;
               st_q <= S_RLOCK;
            end
            S_RLOCK: if (got_lo_q) begin
               WORD_DATA <= {hi_q, LINK.rdata};
               WORD_VALID <= cnt_q >= 13'(emr_pkg::JUNK_WORDS);
               cnt_q <= cnt_q + 13'h0001;
               if (cnt_q + 13'h0001 < emr_pkg::WORD_CNT_TOTAL) begin
                  st_q <= S_WAIT;
               end else begin
                  wr_q <= 1'b1;
                  addr_q <= emr_pkg::OFF_LOCK_MON;
                  wdata_q <= emr_pkg::RST_LOCK_MON;
                  st_q <= S_RSCALE;
               end
            end else begin
               st_q <= S_RSCALE;
            end
            S_RSCALE: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_SCALE;
               wdata_q <= emr_pkg::RST_SCALE;
               st_q <= S_RRANGE;
            end
            S_RRANGE: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_RANGE;
               wdata_q <= {RANGE, 6'h20};
               st_q <= S_RCTRL;
            end
            S_RCTRL: begin
               wr_q <= 1'b1;
               addr_q <= emr_pkg::OFF_CTRL;
               wdata_q <= 8'h00;
               BUSY <= 1'b0;
               DONE <= 1'b1;
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
   assign LINK.addr = addr_q;
   assign LINK.wdata = wdata_q;
   assign LINK.wr = wr_q;
   assign LINK.rd = rd_q;
   assign LINK.burst = 1'b0;
endmodule

// ### verif/emr_link_sva.sv
`timescale 1ns/1ps
module emr_link_sva (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic burst,
   input wire logic [7:0] rdata
);
   logic [7:0] sel_q, page_q, lock_q, scale_q, rng_q;
   logic hi_q, act_q;
   logic [12:0] cnt_q;
   wire logic map_rd = rd && (addr == 8'h25 || addr == 8'h26);
   wire logic adv = rd && hi_q && (addr == 8'h26 || (addr == 8'h25 && burst));
   wire logic go = wr && addr == 8'h24 && wdata[0];
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Shadows of host writes, so the order of setup can be judged
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         sel_q <= 8'h00;
         page_q <= 8'h00;
         lock_q <= 8'h20;
         scale_q <= 8'h40;
         rng_q <= 8'h20;
      end else if (wr) begin
         if (addr == 8'hFC) sel_q <= wdata;
         if (addr == 8'hFF) page_q <= wdata;
         if (addr == 8'h67) lock_q <= wdata;
         if (addr == 8'h2C) scale_q <= wdata;
         if (addr == 8'h11) rng_q <= wdata;
      end
   end
   // Words counted at the byte that completes them
   always_ff @(posedge CORE_CLK) begin
      if (!RST_N) begin
         hi_q <= 1'b0;
         act_q <= 1'b0;
         cnt_q <= 13'h0000;
      end else if (go) begin
         hi_q <= 1'b0;
         act_q <= 1'b1;
         cnt_q <= 13'h0000;
      end else begin
         if (adv) hi_q <= 1'b0;
         else if (rd && addr == 8'h25) hi_q <= 1'b1;
         if (adv) cnt_q <= cnt_q + 13'h0001;
         if (wr && addr == 8'h67 && wdata[5]) act_q <= 1'b0;
      end
   end
   AST_NO_WR_RD: assert property (!(wr && rd)) else $error("strobes overlap");
   AST_PAGE_SEL: assert property (map_rd |-> $onehot(sel_q) && page_q[0])
      else $error("map read without one channel");
   AST_SEL_FIXED: assert property (wr && (addr == 8'hFC || addr == 8'hFF) |-> !act_q)
      else $error("channel changed in capture");
   AST_PREP: assert property (wr && addr == 8'h24 && wdata[7]
      |-> !lock_q[5] && !scale_q[6] && !rng_q[5]) else $error("fast mode before setup");
   AST_START_READ: assert property (go |-> ##[1:16] (rd && addr == 8'h25))
      else $error("no readout after start");
   AST_PAIR: assert property (rd && addr == 8'h26 |-> hi_q) else $error("lower first");
   AST_HOLD: assert property (!rd |=> $stable(rdata)) else $error("read data moved");
   AST_JUNK: assert property (map_rd && act_q && cnt_q < 13'h0004 |=> rdata == 8'h00)
      else $error("junk word not zero");
   AST_FULL: assert property (wr && addr == 8'h67 && wdata[5] && act_q
      |-> cnt_q == emr_pkg::WORD_CNT_TOTAL) else $error("restore before full array");
   COV_START: cover property (go);
   COV_LAST: cover property (adv && cnt_q == 13'h1003);
   COV_RESTORE: cover property (wr && addr == 8'h67 && wdata[5] && act_q);
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   logic CORE_CLK;
   logic RST_N = 1'b0;
   logic START = 1'b0;
   logic [2:0] ch = 3'h0;
   logic [2:0] c;
   logic [1:0] rg = 2'h0;
   logic [15:0] salt, ea, e, wd;
   logic [7:0] eb, ma_a, ma_b;
   logic [7:0] lock = 8'hFF;
   logic [7:0] hop [8];
   logic [7:0] vop [8];
   logic [1:0] vr_a [8];
   logic [1:0] vr_b [8];
   logic [5:0] ph_a, vo_a, ph_b, vo_b;
   logic wv, bsy, dn;
   logic rdv = 1'b0;
   logic en_b = 1'b1;
   logic [31:0] sd = 32'h542BB4D8;
   int n_mismatch = 0;
   int n_compared = 0;
   logic [15:0] qa [$];
   logic [7:0] qb [$];
   emr_link_if la ();
   emr_link_if lb ();
   function automatic logic [15:0] hit(input logic [5:0] p, v, input logic [15:0] s);
      return {v, p, 4'hA} ^ s;
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   emr_device u_emr_device (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(1'b1), .LINK(la),
      .CDR_LOCKED(lock), .HOPEN_RAW(hop), .VOPEN_RAW(vop), .HIT_COUNT(hit(ph_a, vo_a, salt)),
      .MAP_PHASE(ph_a), .MAP_VOLT(vo_a), .VRANGE_SEL(vr_a), .MON_ACTIVE(ma_a));
   // Second device on a bench-driven link reaches registers the host never reads
   emr_device u_emr_device_b (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(en_b), .LINK(lb),
      .CDR_LOCKED(lock), .HOPEN_RAW(hop), .VOPEN_RAW(vop), .HIT_COUNT(hit(ph_b, vo_b, salt)),
      .MAP_PHASE(ph_b), .MAP_VOLT(vo_b), .VRANGE_SEL(vr_b), .MON_ACTIVE(ma_b));
   emr_host u_emr_host (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(1'b1), .LINK(la),
      .START(START), .CHANNEL(ch), .RANGE(rg), .WORD_VALID(wv), .WORD_DATA(wd), .BUSY(bsy),
      .DONE(dn));
   emr_link_sva u_emr_link_sva (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .addr(la.addr),
      .wdata(la.wdata), .wr(la.wr), .rd(la.rd), .burst(la.burst), .rdata(la.rdata));
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bw(input logic [7:0] a, d);
      @(posedge CORE_CLK);
      lb.addr <= a;
      lb.wdata <= d;
      lb.wr <= 1'b1;
      @(posedge CORE_CLK);
      lb.wr <= 1'b0;
   endtask
   task automatic br(input logic [7:0] a, x, input logic b = 1'b0);
      @(posedge CORE_CLK);
      lb.addr <= a;
      lb.burst <= b;
      lb.rd <= 1'b1;
      qb.push_back(x);
      @(posedge CORE_CLK);
      lb.rd <= 1'b0;
   endtask
   // Negative word numbers are the junk words ahead of the map
   task automatic rdmap(input int k0, n, input logic b);
      for (int k = k0; k < n; k++) begin
         e = (k < 0) ? 16'h0000 : hit(k[11:6], k[5:0], salt);
         br(8'h25, e[15:8]);
         br(b ? 8'h25 : 8'h26, e[7:0], b);
      end
   endtask
   always @(posedge CORE_CLK) begin
      if (wv === 1'b1) begin
         ea = (qa.size() != 0) ? qa.pop_front() : ~wd;
         `CHK(wd, ea)
         `CHK(vr_a[ch], rg)
         `CHK(ma_a[ch], 1'b1)
      end
      if (rdv) begin
         eb = qb.pop_front();
         `CHK(lb.rdata, eb)
      end
      rdv <= lb.rd;
   end
   initial begin
      CORE_CLK = 1'b0;
      forever #12.5 CORE_CLK = ~CORE_CLK;
   end
   initial begin
      repeat (90000) @(posedge CORE_CLK);
      n_mismatch++;
      close_out();
   end
   initial begin
      lb.addr = 8'h00;
      lb.wdata = 8'h00;
      lb.wr = 1'b0;
      lb.rd = 1'b0;
      lb.burst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         sd = lfsr(sd);
         hop[i] = sd[7:0];
         vop[i] = sd[15:8];
      end
      salt = sd[31:16];
      c = sd[18:16];
      repeat (10) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      bw(8'hFC, 8'h01 << c);
      bw(8'hFF, 8'h01);
      br(8'h67, 8'h20);
      br(8'h2C, 8'h40);
      br(8'h11, 8'h20);
      br(8'h24, 8'h00);
      br(8'h27, hop[c]);
      br(8'h28, vop[c]);
      bw(8'h27, ~hop[c]);
      br(8'h27, hop[c]);
      br(8'h30, 8'h00);
      bw(8'hFC, 8'h03);
      br(8'h27, 8'h00);
      bw(8'hFC, 8'h01 << c);
      bw(8'h11, 8'h00);
      repeat (3) @(posedge CORE_CLK);
      `CHK(vr_b[c], 2'h3)
      bw(8'h67, 8'h00);
      bw(8'h2C, 8'h00);
      for (int r = 0; r < 4; r++) begin
         bw(8'h11, {r[1:0], 6'h00});
         repeat (3) @(posedge CORE_CLK);
         `CHK(vr_b[c], r[1:0])
      end
      // A write taken while the enable is low must leave the range alone
      en_b <= 1'b0;
      bw(8'h11, 8'h40);
      en_b <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      `CHK(vr_b[c], 2'h3)
      bw(8'h24, 8'h80);
      bw(8'h24, 8'h81);
      br(8'h24, 8'h80);
      repeat (3) @(posedge CORE_CLK);
      `CHK(ma_b[c], 1'b1)
      rdmap(-4, 70, 1'b0);
      rdmap(70, 73, 1'b1);
      bw(8'h24, 8'h81);
      rdmap(-4, 2, 1'b0);
      for (int i = 0; i < 2; i++) begin
         int w;
         sd = lfsr(sd);
         @(posedge CORE_CLK);
         ch <= sd[2:0];
         rg <= sd[4:3];
         salt <= sd[31:16];
         @(posedge CORE_CLK);
         for (int k = 0; k < 4096; k++) qa.push_back(hit(k[11:6], k[5:0], salt));
         START <= 1'b1;
         @(posedge CORE_CLK);
         START <= 1'b0;
         repeat (40) @(posedge CORE_CLK);
         `CHK(bsy, 1'b1)
         START <= 1'b1;
         @(posedge CORE_CLK);
         START <= 1'b0;
         w = 0;
         while (dn !== 1'b1 && w < 40000) begin
            @(posedge CORE_CLK);
            w++;
         end
         repeat (3) @(posedge CORE_CLK);
         `CHK(qa.size(), 0)
         `CHK(vr_a[ch], 2'h3)
         `CHK(ma_a[ch], 1'b0)
      end
      close_out();
   end
endmodule
